// File: cmc_pkg.sv
// cmc_pkg: constants and carrier types of the CAN mode controller.
// assumes a 16-bit register view placed in the low bits of a 32-bit Wishbone bus.
`default_nettype none
package cmc_pkg;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CMC_OFS_CTRL1   = 8'h00;
  localparam logic [7:0] CMC_OFS_FCNT    = 8'h04;
  localparam logic [7:0] CMC_OFS_ISRC    = 8'h08;
  localparam logic [7:0] CMC_OFS_CFG2    = 8'h0C;
  localparam logic [7:0] CMC_OFS_LOCKED  = 8'h10;
  localparam logic [7:0] CMC_OFS_ABORTED = 8'h14;
  // ----------------------------------------
  // control register one fields, then the wake low-pass and filter hit positions
  // ----------------------------------------
  localparam int CMC_BIT_STOP_IDLE = 13;
  localparam int CMC_BIT_ABORT_ALL = 12;
  localparam int CMC_POS_REQ       = 8;
  localparam int CMC_POS_CUR       = 5;
  localparam int CMC_BIT_CAPTURE   = 3;
  localparam int CMC_BIT_PAGE      = 0;
  localparam int CMC_BIT_WAKE_LP   = 14;
  localparam int CMC_POS_FILTHIT   = 8;
  localparam logic [15:0] CMC_CTRL1_WMASK = 16'h3709;
  // ----------------------------------------
  // mode codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    CMC_MODE_NORMAL = 3'h0,
    CMC_MODE_DISABLE = 3'h1,
    CMC_MODE_LOOPBACK = 3'h2,
    CMC_MODE_LISTEN = 3'h3,
    CMC_MODE_CONFIG = 3'h4,
    CMC_MODE_RSVD5 = 3'h5,
    CMC_MODE_RSVD6 = 3'h6,
    CMC_MODE_LISTEN_ALL = 3'h7
  } cmc_mode_t;
  localparam cmc_mode_t CMC_MODE_RESET = CMC_MODE_CONFIG;
  // ----------------------------------------
  // interrupt source codes and counts
  // ----------------------------------------
  localparam logic [6:0] CMC_IC_NONE     = 7'h40;
  localparam logic [6:0] CMC_IC_ERROR    = 7'h41;
  localparam logic [6:0] CMC_IC_WAKE     = 7'h42;
  localparam logic [6:0] CMC_IC_OVERFLOW = 7'h43;
  localparam logic [6:0] CMC_IC_FIFO     = 7'h44;
  localparam logic [4:0] CMC_FCNT_MAX    = 5'h11;
  localparam logic [4:0] CMC_FILT_MAX    = 5'h0F;
  localparam int         CMC_IDLE_BITS   = 11;
  localparam int         CMC_NUM_TXBUF   = 8;
  localparam int         CMC_NUM_BUF     = 16;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } cmc_wb_req_t;
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } cmc_wb_rsp_t;
  // status from the protocol engine
  typedef struct packed {
    logic        bit_tick;
    logic        rx_bit;
    logic        tx_busy;
    logic        rx_done;
    logic        rx_error;
    logic        cpu_idle;
    logic        cpu_sleep;
    logic        err_irq;
    logic        ovf_irq;
    logic        fifo_irq;
    logic [15:0] buf_irq;
    logic [4:0]  filt_hit;
    logic [4:0]  fcnt;
    logic [7:0]  tx_pending;
  } cmc_eng_t;
  // controls to the protocol engine and pins
  typedef struct packed {
    logic       tx_enable;
    logic       rx_enable;
    logic       send_err_ack;
    logic       err_cnt_run;
    logic       err_cnt_clear;
    logic       accept_all;
    logic       loopback;
    logic       tx_pin_own;
    logic       rx_pin_own;
    logic       halted;
    logic       capture_evt;
    logic       page_filter;
    logic       wake_lp;
    logic       wake_flag;
    logic       cfg_unlocked;
    logic [7:0] tx_abort;
  } cmc_ctl_t;
endpackage
`default_nettype wire

// File: cmc_idle_det.sv
// cmc_idle_det: counts consecutive recessive bits and flags a bus idle.
// assumes bit_tick pulses once per sampled bus bit.
`default_nettype none
module cmc_idle_det #(
  parameter int IDLE_BITS = cmc_pkg::CMC_IDLE_BITS
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // bit stream
  input  wire logic bit_tick_i,
  input  wire logic rx_bit_i,
  // result
  output logic      idle_o
);
  import cmc_pkg::*;
  typedef struct packed {
    logic [4:0] cnt;
    logic       idle;
  } cmc_idle_st_t;
  cmc_idle_st_t st_reg, st_next;
  always_comb begin
    st_next = st_reg;
    if (bit_tick_i) begin
      if (!rx_bit_i) begin
        st_next.cnt = 5'h00;
      end else if (st_reg.cnt != 5'(IDLE_BITS)) begin
        st_next.cnt = st_reg.cnt + 5'h01;
      end
    end
    // see R2
    st_next.idle = (st_next.cnt == 5'(IDLE_BITS));
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign idle_o = st_reg.idle;
endmodule
`default_nettype wire

// File: cmc_mode_ctrl.sv
// cmc_mode_ctrl: operating-mode controller with its Wishbone register slave.
// assumes a protocol engine that reports bit ticks, busy and event status.
`default_nettype none
// Functional notes
// R1: request mode bits 10-8, report 7-5
// R2: mode changes only after bus idle; the code changes at once out of configuration or disable
// R3: mode request codes; 101,110 reserved
// R4: reported mode uses same codes
// R5: configuration: no traffic, clear error counters
// R6: protected registers writable only in configuration
// R7: configuration entry waits for transmission end
// R8: disable: no traffic, wake flag may set
// R9: disable after idle, pins released
// R10: wake low-pass enable at bit 14
// R11: disable during start wait aborts frames
// R12: normal mode owns pins, full traffic
// R13: listen only: passive, counters frozen
// R14: listen all: ignore errors, keep data
// R15: loopback joins tx to rx internally
// R16: stop-in-idle halts module when idle
// R17: abort-all aborts, self-clears when done
// R18: capture enable makes receive timer event
// R19: page select picks filter or buffer
// R20: data bit count, invalid above 10001
// R21: matched filter index field, 0-15
// R22: interrupt source code encoding
// R23: reset requests and reports configuration
module cmc_mode_ctrl #(
  parameter int NUM_TXBUF = cmc_pkg::CMC_NUM_TXBUF
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // wishbone slave
  input  wire cmc_pkg::cmc_wb_req_t  wb_req_i,
  output cmc_pkg::cmc_wb_rsp_t       wb_rsp_o,
  // protocol engine status
  input  wire cmc_pkg::cmc_eng_t     eng_i,
  // engine and pin control
  output cmc_pkg::cmc_ctl_t          ctl_o,
  output logic                       config_write_ok_o
);
  import cmc_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic                 ack;
    logic [31:0]          rdat;
    cmc_mode_t            req;
    cmc_mode_t            cur;
    logic                 stop_idle;
    logic                 abort_all;
    logic                 capture;
    logic                 page;
    logic                 wake_lp;
    logic                 start_wait;
    logic [4:0]           wait_cnt;
    logic                 wake_flag;
    logic [7:0]           aborted;
    logic [4:0]           fcnt;
    logic [4:0]           filt;
    logic [6:0]           icode;
    cmc_ctl_t             ctl;
  } cmc_st_t;
  cmc_st_t st_reg, st_next;

  logic bus_idle;

  cmc_idle_det #(
    .IDLE_BITS (CMC_IDLE_BITS)
  ) u_idle (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .bit_tick_i (eng_i.bit_tick),
    .rx_bit_i   (eng_i.rx_bit),
    .idle_o     (bus_idle)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic mode_valid(input cmc_mode_t m);
    mode_valid = (m != CMC_MODE_RSVD5) && (m != CMC_MODE_RSVD6); // see R3
  endfunction

  function automatic logic [6:0] encode_icode(input logic err, input logic wake, input logic ovf,
                                              input logic fifo, input logic [15:0] bufs);
    logic [6:0] c;
    c = CMC_IC_NONE;
    // lowest buffer first, then the fixed sources by priority
    if (err) begin
      c = CMC_IC_ERROR;
    end else if (wake) begin
      c = CMC_IC_WAKE;
    end else if (ovf) begin
      c = CMC_IC_OVERFLOW;
    end else if (fifo) begin
      c = CMC_IC_FIFO;
    end
    for (int i = CMC_NUM_BUF - 1; i >= 0; i--) begin
      if (bufs[i]) begin
        c = 7'(i); // see R22
      end
    end
    encode_icode = c;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic       wr;
  logic       rd;
  logic       in_config;
  logic       can_change;
  logic       active;
  logic [15:0] wd;
  logic [15:0] ctrl1_rd;

  always_comb begin
    st_next   = st_reg;
    wr        = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && !st_reg.ack;
    rd        = wb_req_i.cyc && wb_req_i.stb && !st_reg.ack;
    in_config = (st_reg.cur == CMC_MODE_CONFIG);
    active    = (st_reg.cur != CMC_MODE_CONFIG) && (st_reg.cur != CMC_MODE_DISABLE);
    wd        = wb_req_i.dat[15:0];
    ctrl1_rd  = 16'h0000;
    ctrl1_rd[CMC_BIT_STOP_IDLE]            = st_reg.stop_idle;
    ctrl1_rd[CMC_BIT_ABORT_ALL]            = st_reg.abort_all;
    ctrl1_rd[CMC_POS_REQ +: 3]             = st_reg.req;
    ctrl1_rd[CMC_POS_CUR +: 3]             = st_reg.cur; // see R1 R4
    ctrl1_rd[CMC_BIT_CAPTURE]              = st_reg.capture;
    ctrl1_rd[CMC_BIT_PAGE]                 = st_reg.page;

    // bus answer: one cycle after request, dropped the cycle after
    st_next.ack  = rd;
    st_next.rdat = 32'h0000_0000;
    if (rd && !wb_req_i.we) begin
      case (wb_req_i.adr)
        CMC_OFS_CTRL1:   st_next.rdat[15:0] = ctrl1_rd;
        CMC_OFS_FCNT:    st_next.rdat[4:0]  = st_reg.fcnt;
        CMC_OFS_ISRC:    st_next.rdat[15:0] = {3'h0, st_reg.filt, 1'b0, st_reg.icode};
        CMC_OFS_CFG2:    st_next.rdat[CMC_BIT_WAKE_LP] = st_reg.wake_lp;
        CMC_OFS_LOCKED:  st_next.rdat[0]    = in_config;
        CMC_OFS_ABORTED: st_next.rdat[7:0]  = st_reg.aborted;
        default:         st_next.rdat       = 32'h0000_0000;
      endcase
    end

    // control register one: mode request and runtime bits always writable
    if (wr && wb_req_i.adr == CMC_OFS_CTRL1 && wb_req_i.sel[1]) begin
      if (mode_valid(cmc_mode_t'(wd[CMC_POS_REQ +: 3]))) begin
        st_next.req = cmc_mode_t'(wd[CMC_POS_REQ +: 3]); // see R1
      end
      st_next.stop_idle = wd[CMC_BIT_STOP_IDLE];
      if (wd[CMC_BIT_ABORT_ALL]) begin
        st_next.abort_all = 1'b1;
      end
    end
    if (wr && wb_req_i.adr == CMC_OFS_CTRL1 && wb_req_i.sel[0]) begin
      st_next.capture = wd[CMC_BIT_CAPTURE];
      st_next.page    = wd[CMC_BIT_PAGE];
    end
    // configuration register two (wake low-pass) is locked outside configuration
    if (wr && in_config && wb_req_i.adr == CMC_OFS_CFG2 && wb_req_i.sel[1]) begin
      st_next.wake_lp = wd[CMC_BIT_WAKE_LP]; // see R6 R10
    end
    // sticky abort record, cleared by writing ones; set wins
    if (wr && wb_req_i.adr == CMC_OFS_ABORTED && wb_req_i.sel[0]) begin
      st_next.aborted = st_reg.aborted & ~wd[7:0];
    end

    // transmissions wait for 11 recessive bits after entering a tx mode
    // fresh count from entry: an idle seen before the change must not release the sender
    if (st_reg.start_wait && eng_i.bit_tick) begin
      st_next.wait_cnt = eng_i.rx_bit ? st_reg.wait_cnt + 5'h01 : 5'h00;
      if (eng_i.rx_bit && (st_reg.wait_cnt == 5'(CMC_IDLE_BITS - 1))) begin
        st_next.start_wait = 1'b0; // see R11
      end
    end

    // mode change at bus idle or from an inactive mode; configuration also waits for tx end
    can_change = bus_idle || !active; // see R2
    if (st_reg.req == CMC_MODE_CONFIG && eng_i.tx_busy) begin
      can_change = 1'b0; // see R7
    end
    if (st_reg.req == CMC_MODE_DISABLE && st_reg.start_wait) begin
      can_change = 1'b1; // see R11
      st_next.aborted = st_next.aborted | eng_i.tx_pending;
    end
    if (st_reg.req != st_reg.cur && can_change) begin
      st_next.cur = st_reg.req; // see R9
      st_next.start_wait = (st_reg.req == CMC_MODE_NORMAL) || (st_reg.req == CMC_MODE_LOOPBACK);
      st_next.wait_cnt   = 5'h00;
    end

    // abort-all clears once nothing is pending
    if (st_reg.abort_all && eng_i.tx_pending == 8'h00) begin
      st_next.abort_all = 1'b0; // see R17
    end
    if (st_reg.abort_all && eng_i.tx_pending != 8'h00) begin
      st_next.aborted = st_next.aborted | eng_i.tx_pending;
    end

    // status from engine
    st_next.fcnt  = (eng_i.fcnt > CMC_FCNT_MAX) ? 5'h00 : eng_i.fcnt; // see R20
    st_next.filt  = (eng_i.filt_hit > CMC_FILT_MAX) ? st_reg.filt : eng_i.filt_hit; // see R21
    if (st_reg.cur == CMC_MODE_DISABLE && !eng_i.rx_bit) begin
      st_next.wake_flag = 1'b1; // see R8
    end
    st_next.icode = encode_icode(eng_i.err_irq, st_reg.wake_flag, eng_i.ovf_irq, eng_i.fifo_irq,
                                 eng_i.buf_irq);

    // engine and pin controls from current mode
    st_next.ctl = '0;
    case (st_next.cur)
      CMC_MODE_NORMAL: begin
        st_next.ctl.tx_enable    = !st_next.start_wait; // see R12
        st_next.ctl.rx_enable    = 1'b1;
        st_next.ctl.send_err_ack = 1'b1;
        st_next.ctl.err_cnt_run  = 1'b1;
        st_next.ctl.tx_pin_own   = 1'b1;
        st_next.ctl.rx_pin_own   = 1'b1;
      end
      CMC_MODE_LISTEN: begin
        st_next.ctl.rx_enable  = 1'b1; // see R13
        st_next.ctl.rx_pin_own = 1'b1;
      end
      CMC_MODE_LISTEN_ALL: begin
        st_next.ctl.rx_enable  = 1'b1; // see R14
        st_next.ctl.accept_all = 1'b1;
        st_next.ctl.rx_pin_own = 1'b1;
      end
      CMC_MODE_LOOPBACK: begin
        st_next.ctl.tx_enable = !st_next.start_wait; // see R15
        st_next.ctl.rx_enable = 1'b1;
        st_next.ctl.loopback  = 1'b1;
      end
      CMC_MODE_CONFIG: begin
        st_next.ctl.err_cnt_clear = 1'b1; // see R5
        st_next.ctl.cfg_unlocked  = 1'b1; // see R6
      end
      CMC_MODE_DISABLE: begin
        st_next.ctl.err_cnt_run = 1'b0; // see R8
      end
      default: begin
        st_next.ctl = '0;
      end
    endcase
    // stop in idle freezes traffic but keeps the mode
    st_next.ctl.halted = st_next.stop_idle && eng_i.cpu_idle; // see R16
    if (st_next.ctl.halted) begin
      st_next.ctl.tx_enable = 1'b0;
      st_next.ctl.rx_enable = 1'b0;
    end
    st_next.ctl.capture_evt = st_reg.capture && eng_i.rx_done; // see R18
    st_next.ctl.page_filter = st_next.page; // see R19
    st_next.ctl.wake_lp     = st_next.wake_lp && eng_i.cpu_sleep; // see R10
    st_next.ctl.wake_flag   = st_next.wake_flag;
    st_next.ctl.tx_abort    = (st_next.abort_all || (st_next.cur == CMC_MODE_DISABLE))
                              ? eng_i.tx_pending : 8'h00; // see R11 R17
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg      <= '0;
      st_reg.req  <= CMC_MODE_RESET; // see R23
      st_reg.cur  <= CMC_MODE_RESET;
      st_reg.icode <= CMC_IC_NONE;
      st_reg.ctl.err_cnt_clear <= 1'b1;
      st_reg.ctl.cfg_unlocked  <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_rsp_o.ack       = st_reg.ack;
  assign wb_rsp_o.dat       = st_reg.rdat;
  assign ctl_o              = st_reg.ctl;
  assign config_write_ok_o  = st_reg.ctl.cfg_unlocked;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_reset_mode_config: assert property (@(posedge clk_i) $fell(rst_i) |-> st_reg.cur == CMC_MODE_CONFIG) // see R23
    else $error("mode not configuration after reset");
  chk_mode_change_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.cur != $past(st_reg.cur)) && ($past(st_reg.cur) inside {CMC_MODE_NORMAL, CMC_MODE_LISTEN})
    && !$past(st_reg.start_wait) |-> $past(bus_idle)) // see R2
    else $error("mode changed without idle bus");
  chk_config_no_tx: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.cur == CMC_MODE_CONFIG) && (st_reg.cur != $past(st_reg.cur)) |-> !$past(eng_i.tx_busy)) // see R7
    else $error("configuration entered during transmission");
  chk_config_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 st_reg.cur == CMC_MODE_CONFIG |-> !ctl_o.tx_enable && !ctl_o.rx_enable && ctl_o.err_cnt_clear) // see R5
    else $error("traffic in configuration");
  chk_lock_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 config_write_ok_o == (st_reg.cur == CMC_MODE_CONFIG)) // see R6
    else $error("lock disagrees with mode");
  chk_listen_passive: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 st_reg.cur == CMC_MODE_LISTEN |-> !ctl_o.tx_pin_own && !ctl_o.send_err_ack && !ctl_o.err_cnt_run) // see R13
    else $error("listen only not passive");
  chk_loop_pins: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 st_reg.cur == CMC_MODE_LOOPBACK |-> ctl_o.loopback && !ctl_o.tx_pin_own && !ctl_o.rx_pin_own) // see R15
    else $error("loopback pins wrong");
  chk_disable_pins: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 st_reg.cur == CMC_MODE_DISABLE |-> !ctl_o.tx_pin_own && !ctl_o.rx_enable) // see R9
    else $error("disable keeps pins");
  chk_abort_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg.abort_all && eng_i.tx_pending == 8'h00 |=> !st_reg.abort_all || $past(wr)) // see R17
    else $error("abort-all not cleared");
  chk_wb_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack longer than one cycle");
  chk_req_not_rsvd: assert property (@(posedge clk_i) disable iff (rst_i) mode_valid(st_reg.req)) // see R3
    else $error("reserved mode request stored");
  chk_start_wait_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // see R11
    ##1 st_reg.start_wait |-> !ctl_o.tx_enable)
    else $error("transmit enabled during start wait");
  chk_halt_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // see R16
    ##1 ctl_o.halted |-> !ctl_o.tx_enable && !ctl_o.rx_enable)
    else $error("traffic while halted");
  chk_listen_all_rx: assert property (@(posedge clk_i) disable iff (rst_i) // see R14
    ##1 st_reg.cur == CMC_MODE_LISTEN_ALL |-> ctl_o.accept_all && !ctl_o.tx_enable)
    else $error("listen all controls wrong");
  chk_fcnt_range: assert property (@(posedge clk_i) disable iff (rst_i) st_reg.fcnt <= CMC_FCNT_MAX) // see R20
    else $error("filter count out of range");
  chk_filt_range: assert property (@(posedge clk_i) disable iff (rst_i) st_reg.filt <= CMC_FILT_MAX) // see R21
    else $error("filter index out of range");
  cov_start_abort: cover property (@(posedge clk_i) disable iff (rst_i)
    $fell(st_reg.start_wait) && st_reg.cur == CMC_MODE_DISABLE);
  cov_enter_normal: cover property (@(posedge clk_i) disable iff (rst_i)
    $past(st_reg.cur) == CMC_MODE_CONFIG && st_reg.cur == CMC_MODE_NORMAL);
  cov_enter_disable: cover property (@(posedge clk_i) disable iff (rst_i)
    $past(st_reg.cur) != CMC_MODE_DISABLE && st_reg.cur == CMC_MODE_DISABLE);
  cov_abort_all: cover property (@(posedge clk_i) disable iff (rst_i) $fell(st_reg.abort_all));
endmodule
`default_nettype wire

// File: cmc_bus_model.sv
// cmc_bus_model: other CAN nodes and the engine's bit timing, as seen by the mode controller.
// assumes one bus bit every BIT_CYC clocks; the bus stays recessive unless traffic is asked for.
`default_nettype none
module cmc_bus_model #(
  parameter int BIT_CYC = 8
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // scenario control
  input  wire logic traffic_i,
  input  wire logic tx_hold_i,
  // bit stream
  output logic      bit_tick_o,
  output logic      rx_bit_o,
  output logic      tx_busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // bit timing
  // ----------------------------------------
  int   cnt;
  logic tgl;
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 0;
      tgl <= 1'b0;
    end else begin
      cnt <= (cnt == BIT_CYC - 1) ? 0 : cnt + 1;
      if (cnt == BIT_CYC - 1) begin
        tgl <= ~tgl;
      end
    end
  end
  assign bit_tick_o = (cnt == BIT_CYC - 1);
  // busy nodes put a dominant bit in every other slot, so no idle can build up
  assign rx_bit_o   = traffic_i ? tgl : 1'b1;
  assign tx_busy_o  = tx_hold_i;
endmodule
`default_nettype wire

// File: tb_top.sv
// tb_top: self-checking bench of the CAN mode controller.
// assumes cmc_pkg, cmc_mode_ctrl and cmc_bus_model are compiled first.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cmc_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        clk_i;
  logic        rst_i;
  cmc_wb_req_t wq;
  cmc_wb_rsp_t rsp;
  cmc_eng_t    eng;
  cmc_eng_t    eng_i;
  cmc_ctl_t    ctl;
  logic        cfg_ok;
  logic        tick;
  logic        rxb;
  logic        txb;
  logic        traffic;
  logic        tx_hold;
  logic [31:0] q[$];
  logic [31:0] m_e;
  logic [15:0] rd;
  int          failures;
  int          checks;
  int          cyc_n;
  always_comb begin
    eng_i          = eng;
    eng_i.bit_tick = tick;
    eng_i.rx_bit   = rxb;
    eng_i.tx_busy  = txb;
  end
  cmc_mode_ctrl #(.NUM_TXBUF(8)) i_cmc_mode_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wq), .wb_rsp_o(rsp),
    .eng_i(eng_i), .ctl_o(ctl), .config_write_ok_o(cfg_ok));
  cmc_bus_model i_cmc_bus_model (.clk_i(clk_i), .rst_i(rst_i), .traffic_i(traffic), .tx_hold_i(tx_hold),
    .bit_tick_o(tick), .rx_bit_o(rxb), .tx_busy_o(txb));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // checking
  // ----------------------------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // each ack takes the oldest note; mask zero means nothing to compare
  always @(posedge clk_i) begin
    if (rsp.ack === 1'b1) begin
      m_e = (q.size() > 0) ? q.pop_front() : 32'hFFFF0000;
      chk("read data", m_e[15:0], rsp.dat[15:0] & m_e[31:16]);
    end
  end
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      failures++;
      conclude();
    end
  end
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [15:0] m,
                     input logic [15:0] e);
    q.push_back({m, e});
    wq <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'h3, dat: {16'h0, d}};
    do begin
      @(posedge clk_i);
    end while (rsp.ack !== 1'b1);
    rd = rsp.dat[15:0];
    wq <= '0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d, 16'h0, 16'h0);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    bus(1'b0, a, 16'h0, m, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wait_mode(input logic [2:0] md);
    int n;
    n = 0;
    do begin
      rdc(CMC_OFS_CTRL1, 16'h0, 16'h0);
      n++;
    end while (rd[7:5] !== md && n < 300);
    chk("current mode", {13'h0, md}, {13'h0, rd[7:5]});
  endtask
  // order: tx_pin_own rx_pin_own loopback accept_all send_err_ack err_cnt_run
  task automatic chk_ctl(input logic [5:0] e, input logic [5:0] m);
    chk("mode controls", {10'h0, e & m}, {10'h0, {ctl.tx_pin_own, ctl.rx_pin_own, ctl.loopback,
        ctl.accept_all, ctl.send_err_ack, ctl.err_cnt_run} & m});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    logic [7:0] p;
    logic [4:0] v;
    int         k;
    wq = '0;
    eng = '0;
    traffic = 1'b0;
    tx_hold = 1'b0;
    rst_i = 1'b1;
    failures = 0;
    checks = 0;
    cyc_n = 0;
    void'($urandom(32'h84E8));
    wt(6);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(CMC_OFS_CTRL1, 16'h37E9, 16'h0480);
    chk("config write ok", 16'h1, {15'h0, cfg_ok});
    for (k = 0; k < 4; k++) begin
      v = (k == 0) ? 5'h11 : (k == 1) ? 5'h12 : 5'($urandom_range(0, 31));
      eng.fcnt <= v;
      wt(1);
      rdc(CMC_OFS_FCNT, 16'h001F, (v > 5'h11) ? 16'h0 : {11'h0, v});
    end
    for (k = 0; k < 16; k++) begin
      v = 5'($urandom_range(0, 15));
      eng.buf_irq <= 16'hFFFF << k;
      eng.filt_hit <= v;
      wt(1);
      rdc(CMC_OFS_ISRC, 16'h1F7F, {3'h0, v, 1'b0, 7'(k)});
    end
    eng.buf_irq <= 16'h0;
    eng.filt_hit <= 5'h13;
    eng.err_irq <= 1'b1;
    eng.ovf_irq <= 1'b1;
    eng.fifo_irq <= 1'b1;
    wt(1);
    rdc(CMC_OFS_ISRC, 16'h1F7F, {3'h0, v, 8'h41});
    eng.err_irq <= 1'b0;
    wt(1);
    rdc(CMC_OFS_ISRC, 16'h007F, 16'h0043);
    eng.ovf_irq <= 1'b0;
    wt(1);
    rdc(CMC_OFS_ISRC, 16'h007F, 16'h0044);
    eng.fifo_irq <= 1'b0;
    wt(1);
    rdc(CMC_OFS_ISRC, 16'h007F, 16'h0040);
    wr(CMC_OFS_CFG2, 16'h4000);
    rdc(CMC_OFS_CFG2, 16'h4000, 16'h4000);
    chk("wake filter awake", 16'h0, {15'h0, ctl.wake_lp});
    eng.cpu_sleep <= 1'b1;
    wt(2);
    chk("wake filter", 16'h1, {15'h0, ctl.wake_lp});
    eng.cpu_sleep <= 1'b0;
    p = 8'($urandom_range(1, 255));
    eng.tx_pending <= p;
    wr(CMC_OFS_CTRL1, 16'h1400);
    chk("abort strobes", {8'h0, p}, {8'h0, ctl.tx_abort});
    rdc(CMC_OFS_CTRL1, 16'h1000, 16'h1000);
    eng.tx_pending <= 8'h0;
    wt(3);
    rdc(CMC_OFS_CTRL1, 16'h1000, 16'h0000);
    wr(CMC_OFS_CTRL1, 16'h2409);
    eng.rx_done <= 1'b1;
    @(posedge clk_i);
    eng.rx_done <= 1'b0;
    k = 0;
    repeat (4) begin
      @(posedge clk_i);
      if (ctl.capture_evt === 1'b1) k++;
    end
    chk("capture events", 16'h1, 16'(k));
    chk("page select", 16'h1, {15'h0, ctl.page_filter});
    eng.cpu_idle <= 1'b1;
    wt(3);
    chk("halted", 16'h1, {15'h0, ctl.halted});
    wr(CMC_OFS_CTRL1, 16'h0400);
    wt(2);
    chk("running in idle", 16'h0, {15'h0, ctl.halted});
    eng.cpu_idle <= 1'b0;
    wr(CMC_OFS_CTRL1, 16'h0000);
    wait_mode(3'h0);
    chk_ctl(6'b110011, 6'b111111);
    wr(CMC_OFS_CFG2, 16'h0000);
    rdc(CMC_OFS_CFG2, 16'h4000, 16'h4000);
    chk("config write ok", 16'h0, {15'h0, cfg_ok});
    traffic <= 1'b1;
    wt(20);
    wr(CMC_OFS_CTRL1, 16'h0300);
    wt(200);
    rdc(CMC_OFS_CTRL1, 16'h00E0, 16'h0000);
    traffic <= 1'b0;
    wait_mode(3'h3);
    chk_ctl(6'b000000, 6'b101111);
    wr(CMC_OFS_CTRL1, 16'h0700);
    wait_mode(3'h7);
    chk_ctl(6'b000100, 6'b000100);
    wr(CMC_OFS_CTRL1, 16'h0200);
    wait_mode(3'h2);
    chk_ctl(6'b001000, 6'b111000);
    wr(CMC_OFS_CTRL1, 16'h0500);
    rdc(CMC_OFS_CTRL1, 16'h07E0, 16'h0240);
    tx_hold <= 1'b1;
    wr(CMC_OFS_CTRL1, 16'h0400);
    wt(200);
    rdc(CMC_OFS_CTRL1, 16'h00E0, 16'h0040);
    tx_hold <= 1'b0;
    wait_mode(3'h4);
    chk("config counters", 16'h4, {13'h0, ctl.err_cnt_clear, ctl.tx_enable, ctl.rx_enable});
    wr(CMC_OFS_ABORTED, 16'h00FF);
    rdc(CMC_OFS_ABORTED, 16'h00FF, 16'h0000);
    eng.tx_pending <= p;
    wr(CMC_OFS_CTRL1, 16'h0000);
    chk("start wait", 16'h0, {15'h0, ctl.tx_enable});
    wr(CMC_OFS_CTRL1, 16'h0100);
    wait_mode(3'h1);
    rdc(CMC_OFS_ABORTED, 16'h00FF, {8'h0, p});
    chk_ctl(6'b000000, 6'b110000);
    chk("disabled traffic", 16'h0, {14'h0, ctl.tx_enable, ctl.rx_enable});
    eng.tx_pending <= 8'h0;
    wr(CMC_OFS_ABORTED, 16'h00FF);
    rdc(CMC_OFS_ABORTED, 16'h00FF, 16'h0000);
    traffic <= 1'b1;
    wt(100);
    traffic <= 1'b0;
    chk("wake flag", 16'h1, {15'h0, ctl.wake_flag});
    rdc(CMC_OFS_ISRC, 16'h007F, 16'h0042);
    wt(2);
    conclude();
  end
endmodule
`default_nettype wire
